// ### uart_enh_cfg_defines.vh
// Summary of operation
// - clear mode 0: pause flag clears on status read or resume; special on read or next char
// - clear mode 1: pause and special flags clear only on status read
// - resume flag clears only on status read, in every clear mode
// - divisor is high:low bytes plus fractional low nibble over sixteen
// - fractional register reachable only while enhanced feature bit 4 set
// - sampling field: 00 16X, 01 8X, 1x 4X; default 16X
// - fractional bit 6 selects shared or separate transmit and receive generators
// - bits 7:6 route divisor writes: 00 shared, 01 tx, 11 rx, 10 nothing
// - trigger register sets rx or tx level by feature bit 7, table D only
// - fifo count shows rx or tx level by bit 7; reads zero unless line control holds 0xBF or swap bit set
// - swap bit set: scratchpad reads count, writes go to mode select
// - sleep input enters sleep after current tx and rx bytes finish
// - powerdown pin output: low while asleep, high otherwise
// - infrared input idles low, or inverted idling high when bit 2 set
// - rs485: direction rises one bit after last stop, falls on fifo load
// - rs485: transmit interrupt waits for empty shift register
// - feature bits 5:4 pick trigger table A to D for both directions
// - enhanced bits 3:2 pick transmit flow control pairs
// - enhanced bits 1:0 pick receive comparison, 11 depends on transmit bits
// - dual selection matches either character when transmit bits differ, else one two-character sequence
// - enhanced bit 4 gates enhanced bits; clearing latches; reset clears
`ifndef UART_ENH_CFG_DEFINES_VH
`define UART_ENH_CFG_DEFINES_VH
`define A_DIV_LOW 4'h0
`define A_DIV_HIGH 4'h1
`define A_FRAC 4'h2
`define A_TRIG 4'h3
`define A_COUNT 4'h4
`define A_FEAT 4'h5
`define A_ENH 4'h6
`define A_SCRATCH 4'h7
`define A_LINE 4'h8
`define A_ISTAT 4'h9
`define A_MODE 4'hA
`define LINE_ENH_KEY 8'hBF
`define RST_DIV_LOW 8'h01
`define RST_DIV_HIGH 8'h00
`define RST_TRIG 8'h01
`define RST_SCRATCH 8'hFF
`define FIFO_DEPTH 8'h80
`define SAMP_16X 2'h0
`define SAMP_8X 2'h1
`define SAMP_4X 2'h2
`define ROUTE_SHARED 2'h0
`define ROUTE_TX 2'h1
`define ROUTE_NONE 2'h2
`define ROUTE_RX 2'h3
`define TABLE_D 2'h3
`define MATCH_NONE 3'h0
`define MATCH_PAIR1 3'h1
`define MATCH_PAIR2 3'h2
`define MATCH_EITHER 3'h3
`define MATCH_SEQ 3'h4
`define FB_PIN_OUT 0
`define FB_IR_INV 2
`define FB_RS485 3
`define FB_SWAP 6
`define FB_TRG_TX 7
`define EB_ENABLE 4
`define MB_RTS_INV 3
`define MB_CLR_MODE 7
`endif

// ### uart_enh_cfg.v
`timescale 1ns/1ps
`include "uart_enh_cfg_defines.vh"
module uart_enh_cfg (
  input wire CLK, // 20 MHz clock
  input wire RESET, // async, active high
  input wire [3:0] ADDR, // register address
  input wire [7:0] WDATA, // write data
  input wire WR, // write strobe
  input wire RD, // read strobe
  output reg [7:0] RDATA, // read data, cycle after RD
  input wire PAUSE_RX, // pause char received
  input wire RESUME_RX, // resume char received
  input wire SPECIAL_RX, // special char received
  input wire CHAR_RX, // any char received
  input wire RX_PUSH, // rx fifo write
  input wire RX_POP, // rx fifo read
  input wire TX_PUSH, // tx fifo write
  input wire TX_POP, // tx fifo to shifter
  input wire THR_EMPTY, // holding register empty
  input wire TSR_EMPTY, // shift register empty
  input wire BIT_TICK, // one pulse per bit time
  input wire TX_BUSY, // byte being sent
  input wire RX_BUSY, // byte being received
  input wire SW_SLEEP, // sleep request from core
  input wire SLEEP_PIN_IN, // shared pin, input side
  output reg SLEEP_PIN_OUT, // shared pin, output level
  output reg SLEEP_PIN_OE_N, // low while driving
  input wire RX_PIN, // serial receive pin
  output reg RX_DATA, // decoded receive level
  output reg ASLEEP, // sleep state
  output reg RTS_N, // direction pin
  output reg TX_INT, // transmit interrupt
  output reg XOFF_INT, // pause interrupt flag
  output reg SPECIAL_INT, // special char flag
  output reg RESUME_INT, // resume interrupt flag
  output reg [15:0] TX_DIV, // tx integer divisor
  output reg [3:0] TX_FRAC, // tx fraction sixteenths
  output reg [1:0] TX_SAMPLE, // tx sampling rate
  output reg [15:0] RX_DIV, // rx integer divisor
  output reg [3:0] RX_FRAC, // rx fraction sixteenths
  output reg [1:0] RX_SAMPLE, // rx sampling rate
  output reg [7:0] TX_TRIG, // tx programmed level
  output reg [7:0] RX_TRIG, // rx programmed level
  output reg [1:0] TRIG_TABLE, // trigger table
  output reg [1:0] TX_FLOW, // tx flow select
  output reg [2:0] RX_MATCH // rx compare mode
);

  reg [7:0] div_low_sh;
  reg [7:0] div_high_sh;
  reg [5:0] frac_sh;
  reg [7:0] div_low_tx;
  reg [7:0] div_high_tx;
  reg [5:0] frac_tx;
  reg [7:0] div_low_rx;
  reg [7:0] div_high_rx;
  reg [5:0] frac_rx;
  reg [1:0] route;
  reg [7:0] feature;
  reg [7:0] enhanced;
  reg [7:0] mode_sel;
  reg [7:0] scratch;
  reg [7:0] line_ctl;
  reg [7:0] rx_count;
  reg [7:0] tx_count;
  reg [7:0] next_rdata;
  reg sleep_m;
  reg sleep_s;
  reg rx_m;
  reg rx_s;
  reg rs_tx_dir;
  reg rs_wait;

  // sampling field to rate code
  function [1:0] samp;
    input [1:0] f;
    begin
      samp = f[1] ? `SAMP_4X : f[0] ? `SAMP_8X : `SAMP_16X;
    end
  endfunction

  // receive comparison from flow select
  function [2:0] rxm;
    input [3:0] e;
    begin
      case (e[1:0])
        2'h2: rxm = `MATCH_PAIR1;
        2'h1: rxm = `MATCH_PAIR2;
        2'h3: rxm = (e[3] ^ e[2]) ? `MATCH_EITHER : `MATCH_SEQ;
        default: rxm = `MATCH_NONE;
      endcase
    end
  endfunction

  // fifo level after push and pop, saturating
  function [7:0] lvl;
    input [7:0] c;
    input p;
    input q;
    begin
      lvl = c;
      if (p && !q && c != `FIFO_DEPTH) begin
        lvl = c + 8'h01;
      end else if (q && !p && c != 8'h00) begin
        lvl = c - 8'h01;
      end
    end
  endfunction

  wire enh_en = enhanced[`EB_ENABLE];
  wire wr_frac = WR && ADDR == `A_FRAC && enh_en;
  wire wr_low = WR && ADDR == `A_DIV_LOW;
  wire wr_high = WR && ADDR == `A_DIV_HIGH;
  wire [1:0] wr_route = wr_frac ? WDATA[7:6] : route;
  wire sel_sh = wr_route == `ROUTE_SHARED;
  wire sel_tx = wr_route == `ROUTE_TX;
  wire sel_rx = wr_route == `ROUTE_RX;
  wire swap = feature[`FB_SWAP];
  wire cnt_ok = swap || line_ctl == `LINE_ENH_KEY;
  wire [7:0] count_sel = feature[`FB_TRG_TX] ? tx_count : rx_count;
  wire istat_rd = RD && ADDR == `A_ISTAT;
  wire clr_mode = mode_sel[`MB_CLR_MODE];
  wire tx_idle = TSR_EMPTY && THR_EMPTY && tx_count == 8'h00;

  // divisor and fractional storage
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_low_sh <= `RST_DIV_LOW;
      div_high_sh <= `RST_DIV_HIGH;
      frac_sh <= 6'h00;
      div_low_tx <= `RST_DIV_LOW;
      div_high_tx <= `RST_DIV_HIGH;
      frac_tx <= 6'h00;
      div_low_rx <= `RST_DIV_LOW;
      div_high_rx <= `RST_DIV_HIGH;
      frac_rx <= 6'h00;
      route <= `ROUTE_SHARED;
    end else begin
      if (wr_frac) begin
        route <= WDATA[7:6];
      end
      if (sel_sh) begin
        if (wr_low) begin
          div_low_sh <= WDATA;
        end
        if (wr_high) begin
          div_high_sh <= WDATA;
        end
        if (wr_frac) begin
          frac_sh <= WDATA[5:0];
        end
      end
      if (sel_tx) begin
        if (wr_low) begin
          div_low_tx <= WDATA;
        end
        if (wr_high) begin
          div_high_tx <= WDATA;
        end
        if (wr_frac) begin
          frac_tx <= WDATA[5:0];
        end
      end
      if (sel_rx) begin
        if (wr_low) begin
          div_low_rx <= WDATA;
        end
        if (wr_high) begin
          div_high_rx <= WDATA;
        end
        if (wr_frac) begin
          frac_rx <= WDATA[5:0];
        end
      end
    end
  end

  // control registers
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      feature <= 8'h00;
      enhanced <= 8'h00;
      mode_sel <= 8'h00;
      scratch <= `RST_SCRATCH;
      line_ctl <= 8'h00;
      TX_TRIG <= `RST_TRIG;
      RX_TRIG <= `RST_TRIG;
    end else if (WR) begin
      case (ADDR)
        `A_FEAT: feature <= WDATA;
        `A_LINE: line_ctl <= WDATA;
        `A_ENH: begin
          enhanced[7:4] <= WDATA[7:4];
          if (enh_en) begin
            enhanced[3:0] <= WDATA[3:0];
          end
        end
        `A_SCRATCH: begin
          if (swap) begin
            mode_sel <= WDATA;
          end else begin
            scratch <= WDATA;
          end
        end
        `A_TRIG: begin
          if (feature[5:4] == `TABLE_D) begin
            if (feature[`FB_TRG_TX]) begin
              TX_TRIG <= WDATA;
            end else begin
              RX_TRIG <= WDATA;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // read mux, data in the following cycle
  always @* begin
    next_rdata = 8'h00;
    case (ADDR)
      `A_DIV_LOW: next_rdata = route == `ROUTE_RX ? div_low_rx :
        route == `ROUTE_TX ? div_low_tx : div_low_sh;
      `A_DIV_HIGH: next_rdata = route == `ROUTE_RX ? div_high_rx :
        route == `ROUTE_TX ? div_high_tx : div_high_sh;
      `A_FRAC: next_rdata = enh_en ? {route, route == `ROUTE_RX ? frac_rx :
        route == `ROUTE_TX ? frac_tx : frac_sh} : 8'h00;
      `A_COUNT: next_rdata = cnt_ok ? count_sel : 8'h00;
      `A_FEAT: next_rdata = feature;
      `A_ENH: next_rdata = enhanced;
      `A_SCRATCH: next_rdata = swap ? count_sel : scratch;
      `A_LINE: next_rdata = line_ctl;
      `A_ISTAT: next_rdata = {5'h00, RESUME_INT, SPECIAL_INT, XOFF_INT};
      `A_MODE: next_rdata = {ASLEEP, rs_tx_dir, tx_count == 8'h00,
        rx_count == 8'h00, 2'h0, route};
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // fifo level counters
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_count <= 8'h00;
      tx_count <= 8'h00;
    end else begin
      rx_count <= lvl(rx_count, RX_PUSH, RX_POP);
      tx_count <= lvl(tx_count, TX_PUSH, TX_POP);
    end
  end

  // interrupt flags; a new event wins over a clear
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      XOFF_INT <= 1'b0;
      SPECIAL_INT <= 1'b0;
      RESUME_INT <= 1'b0;
    end else begin
      if (PAUSE_RX) begin
        XOFF_INT <= 1'b1;
      end else if (istat_rd || (!clr_mode && RESUME_RX)) begin
        XOFF_INT <= 1'b0;
      end
      if (SPECIAL_RX) begin
        SPECIAL_INT <= 1'b1;
      end else if (istat_rd || (!clr_mode && CHAR_RX)) begin
        SPECIAL_INT <= 1'b0;
      end
      if (RESUME_RX) begin
        RESUME_INT <= 1'b1;
      end else if (istat_rd) begin
        RESUME_INT <= 1'b0;
      end
    end
  end

  // pin synchronisers
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sleep_m <= 1'b0;
      sleep_s <= 1'b0;
      rx_m <= 1'b0;
      rx_s <= 1'b0;
    end else begin
      sleep_m <= SLEEP_PIN_IN;
      sleep_s <= sleep_m;
      rx_m <= RX_PIN;
      rx_s <= rx_m;
    end
  end

  // sleep and shared pin
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ASLEEP <= 1'b0;
      SLEEP_PIN_OUT <= 1'b1;
      SLEEP_PIN_OE_N <= 1'b1;
    end else begin
      if (feature[`FB_PIN_OUT]) begin
        if (SW_SLEEP && !TX_BUSY && !RX_BUSY) begin
          ASLEEP <= 1'b1;
        end else if (!SW_SLEEP) begin
          ASLEEP <= 1'b0;
        end
        SLEEP_PIN_OE_N <= 1'b0;
        SLEEP_PIN_OUT <= !ASLEEP;
      end else begin
        if (sleep_s && !TX_BUSY && !RX_BUSY) begin
          ASLEEP <= 1'b1;
        end else if (!sleep_s) begin
          ASLEEP <= 1'b0;
        end
        SLEEP_PIN_OE_N <= 1'b1;
        SLEEP_PIN_OUT <= 1'b1;
      end
    end
  end

  // rs485 direction and transmit interrupt
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rs_tx_dir <= 1'b0;
      rs_wait <= 1'b0;
      RTS_N <= 1'b1;
      TX_INT <= 1'b0;
    end else begin
      if (TX_PUSH) begin
        rs_tx_dir <= 1'b1;
        rs_wait <= 1'b0;
      end else if (rs_tx_dir && tx_idle) begin
        if (rs_wait && BIT_TICK) begin
          rs_tx_dir <= 1'b0;
          rs_wait <= 1'b0;
        end else if (BIT_TICK) begin
          rs_wait <= 1'b1;
        end
      end
      if (feature[`FB_RS485]) begin
        RTS_N <= !rs_tx_dir ^ mode_sel[`MB_RTS_INV];
        TX_INT <= THR_EMPTY && TSR_EMPTY;
      end else begin
        RTS_N <= 1'b1;
        TX_INT <= THR_EMPTY;
      end
    end
  end

  // generator outputs, flow select and ir decode
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TX_DIV <= {`RST_DIV_HIGH, `RST_DIV_LOW};
      RX_DIV <= {`RST_DIV_HIGH, `RST_DIV_LOW};
      TX_FRAC <= 4'h0;
      RX_FRAC <= 4'h0;
      TX_SAMPLE <= `SAMP_16X;
      RX_SAMPLE <= `SAMP_16X;
      TRIG_TABLE <= 2'h0;
      TX_FLOW <= 2'h0;
      RX_MATCH <= `MATCH_NONE;
      RX_DATA <= 1'b0;
    end else begin
      if (route[0]) begin
        TX_DIV <= {div_high_tx, div_low_tx};
        TX_FRAC <= frac_tx[3:0];
        TX_SAMPLE <= samp(frac_tx[5:4]);
        RX_DIV <= {div_high_rx, div_low_rx};
        RX_FRAC <= frac_rx[3:0];
        RX_SAMPLE <= samp(frac_rx[5:4]);
      end else begin
        TX_DIV <= {div_high_sh, div_low_sh};
        TX_FRAC <= frac_sh[3:0];
        TX_SAMPLE <= samp(frac_sh[5:4]);
        RX_DIV <= {div_high_sh, div_low_sh};
        RX_FRAC <= frac_sh[3:0];
        RX_SAMPLE <= samp(frac_sh[5:4]);
      end
      TRIG_TABLE <= feature[5:4];
      TX_FLOW <= enhanced[3:2];
      RX_MATCH <= rxm(enhanced[3:0]);
      RX_DATA <= feature[`FB_IR_INV] ? !rx_s : rx_s;
    end
  end

endmodule // uart_enh_cfg

// ### uart_enh_cfg_checker.sv
`timescale 1ns/1ps
module uart_enh_cfg_checker (
  input wire CLK, // clock
  input wire RESET, // async reset
  input wire [3:0] ADDR, // address
  input wire [7:0] WDATA, // write data
  input wire WR, // write strobe
  input wire RD, // read strobe
  input wire PAUSE_RX, // pause char event
  input wire RESUME_RX, // resume char event
  input wire SPECIAL_RX, // special char event
  input wire TX_BUSY, // tx byte busy
  input wire RX_BUSY, // rx byte busy
  input wire XOFF_INT, // pause flag
  input wire SPECIAL_INT, // special flag
  input wire RESUME_INT, // resume flag
  input wire ASLEEP, // sleep state
  input wire SLEEP_PIN_OUT, // powerdown level
  input wire SLEEP_PIN_OE_N, // pin drive enable
  input wire [3:0] TX_FRAC, // tx fraction
  input wire [3:0] RX_FRAC, // rx fraction
  input wire [1:0] TX_SAMPLE, // tx sampling
  input wire [1:0] RX_SAMPLE // rx sampling
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  pause_set_a: assert property (PAUSE_RX |=> XOFF_INT)
    else $error("pause flag missed");
  special_set_a: assert property (SPECIAL_RX |=> SPECIAL_INT)
    else $error("special flag missed");
  resume_set_a: assert property (RESUME_RX |=> RESUME_INT)
    else $error("resume flag missed");
  resume_hold_a: assert property (RESUME_INT && !(RD && ADDR == 4'h9) |=> RESUME_INT)
    else $error("resume flag lost");
  istat_clear_a: assert property (RD && ADDR == 4'h9 && !(PAUSE_RX || RESUME_RX || SPECIAL_RX)
    |=> !(XOFF_INT || SPECIAL_INT || RESUME_INT))
    else $error("status read kept a flag");
  sample_legal_a: assert property (TX_SAMPLE != 2'h3 && RX_SAMPLE != 2'h3)
    else $error("bad sampling code");
  route_none_a: assert property (WR && ADDR == 4'h2 && WDATA[7:6] == 2'h2 && $past(!WR)
    |=> $stable(TX_FRAC) && $stable(RX_FRAC) && $stable(TX_SAMPLE) && $stable(RX_SAMPLE))
    else $error("route 10 changed a generator");
  pin_level_a: assert property (!SLEEP_PIN_OE_N && $past(!SLEEP_PIN_OE_N)
    |-> SLEEP_PIN_OUT == !$past(ASLEEP))
    else $error("powerdown pin level wrong");
  sleep_idle_a: assert property ($rose(ASLEEP) |-> !$past(TX_BUSY) && !$past(RX_BUSY))
    else $error("slept mid byte");
  cover property (PAUSE_RX);
  cover property ($rose(ASLEEP));
  cover property (RD && ADDR == 4'h9 && XOFF_INT);
endmodule // uart_enh_cfg_checker
bind uart_enh_cfg uart_enh_cfg_checker chk (.*);

// ### far_uart.sv
`timescale 1ns/1ps
module far_uart (
  input wire clk, // bench clock
  input wire inv, // line idles high
  input wire send, // drive an ir pulse
  output reg line, // ir line level
  output reg tick // one pulse per bit time
);
  reg [1:0] phase = 2'h0;
  initial line = 1'h0;
  initial tick = 1'h0;
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    tick <= (phase == 2'h3);
    line <= inv ^ send;
  end
endmodule // far_uart

// ### uart_enhanced_baud_flow_config_test.sv
`timescale 1ns/1ps
`include "uart_enh_cfg_defines.vh"
module uart_enhanced_baud_flow_config_test;
  reg CLK = 1'h0, RESET = 1'h1, WR = 1'h0, RD = 1'h0, ir_inv = 1'h0, ir_send = 1'h0;
  reg THR_EMPTY = 1'h1, TSR_EMPTY = 1'h1, TX_BUSY = 1'h0, RX_BUSY = 1'h0;
  reg SW_SLEEP = 1'h0, SLEEP_PIN_IN = 1'h0;
  reg [3:0] ADDR = 4'h0;
  reg [7:0] WDATA = 8'h00, ev = 8'h00, lf = 8'h0B;
  reg [7:0] lo[0:2], hi[0:2];
  reg [3:0] fr[0:2];
  reg [1:0] sm[0:2];
  reg [1:0] rt = 2'h0;
  integer n_rx, n_errors = 0, tests_run = 0, i;
  wire PAUSE_RX, RESUME_RX, SPECIAL_RX, CHAR_RX, RX_PUSH, RX_POP, TX_PUSH, TX_POP;
  wire RX_PIN, BIT_TICK, RX_DATA, ASLEEP, RTS_N, TX_INT, XOFF_INT, SPECIAL_INT, RESUME_INT;
  wire SLEEP_PIN_OUT, SLEEP_PIN_OE_N;
  wire [7:0] RDATA, TX_TRIG, RX_TRIG;
  wire [15:0] TX_DIV, RX_DIV;
  wire [3:0] TX_FRAC, RX_FRAC;
  wire [2:0] RX_MATCH;
  wire [1:0] TX_SAMPLE, RX_SAMPLE, TRIG_TABLE, TX_FLOW;
  assign {TX_POP, TX_PUSH, RX_POP, RX_PUSH, CHAR_RX, SPECIAL_RX, RESUME_RX, PAUSE_RX} = ev;
  uart_enh_cfg uut (.*);
  far_uart far (.clk(CLK), .inv(ir_inv), .send(ir_send), .line(RX_PIN), .tick(BIT_TICK));
  always #25 CLK = ~CLK;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function [2:0] mexp(input [3:0] f);
    case (f[1:0])
      2'h0: mexp = `MATCH_NONE;
      2'h2: mexp = `MATCH_PAIR1;
      2'h1: mexp = `MATCH_PAIR2;
      default: mexp = (f[3] ^ f[2]) ? `MATCH_EITHER : `MATCH_SEQ;
    endcase
  endfunction
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [47:0] s, input [47:0] e);
    begin
      tests_run = tests_run + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge CLK);
      #1;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'h1;
      @(posedge CLK);
      WR <= 1'h0;
      #1;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'h1;
      @(posedge CLK);
      RD <= 1'h0;
      #1;
      chk(RDATA, e);
    end
  endtask
  task pulse(input [7:0] m);
    begin
      @(posedge CLK);
      ev <= m;
      @(posedge CLK);
      ev <= 8'h00;
      #1;
    end
  endtask
  // divisor write mirrored into the model banks: 0 shared, 1 tx, 2 rx, 3 none
  task baud_generator(input [3:0] a, input [7:0] d);
    integer j;
    begin
      wr(a, d);
      if (a == 4'h2)
        rt = d[7:6];
      j = (rt == 2'h0) ? 0 : (rt == 2'h1) ? 1 : (rt == 2'h3) ? 2 : 3;
      if (j < 3) begin
        if (a == 4'h0) lo[j] = d;
        if (a == 4'h1) hi[j] = d;
        if (a == 4'h2) fr[j] = d[3:0];
        if (a == 4'h2) sm[j] = d[5] ? `SAMP_4X : {1'h0, d[4]};
      end
    end
  endtask
  // route bit 6 clear: both directions run from the shared bank; set: tx runs from the tx bank, rx from the rx bank
  task cbrg;
    integer t, r;
    begin
      cyc(1);
      t = rt[0] ? 1 : 0;
      r = rt[0] ? 2 : 0;
      chk({TX_DIV, TX_FRAC, TX_SAMPLE, RX_DIV, RX_FRAC, RX_SAMPLE},
          {hi[t], lo[t], fr[t], sm[t], hi[r], lo[r], fr[r], sm[r]});
    end
  endtask
  initial begin
    #1000000;
    n_errors = n_errors + 1;
    stop_test;
  end
  initial begin
    for (i = 0; i < 3; i = i + 1) begin
      lo[i] = `RST_DIV_LOW;
      hi[i] = `RST_DIV_HIGH;
      fr[i] = 4'h0;
      sm[i] = `SAMP_16X;
    end
    repeat (2) @(posedge CLK);
    RESET <= 1'h0;
    cbrg;
    rd(4'h7, 8'hFF);
    rd(4'hF, 8'h00);
    wr(4'h2, 8'h15);
    rd(4'h2, 8'h00);
    cbrg;
    wr(4'h6, 8'h10);
    baud_generator(4'h2, 8'h15);
    baud_generator(4'h0, lf);
    baud_generator(4'h1, 8'hA5);
    cbrg;
    baud_generator(4'h2, 8'h73);
    baud_generator(4'h0, 8'h34);
    cbrg;
    baud_generator(4'h2, 8'hD7);
    baud_generator(4'h1, 8'h0C);
    cbrg;
    baud_generator(4'h2, 8'h8F);
    baud_generator(4'h0, 8'h77);
    cbrg;
    wr(4'h6, 8'h00);
    wr(4'h2, 8'h00);
    cbrg;
    for (i = 0; i < 16; i = i + 1) begin
      wr(4'h6, 8'h10);
      wr(4'h6, 8'h10 | i[7:0]);
      cyc(1);
      chk(TX_FLOW, i[3:2]);
      chk(RX_MATCH, mexp(i[3:0]));
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h5, {2'h0, i[1:0], 4'h0});
      cyc(1);
      chk(TRIG_TABLE, i[1:0]);
    end
    wr(4'h3, 8'h22);
    wr(4'h5, 8'hB0);
    wr(4'h3, 8'h44);
    chk({TX_TRIG, RX_TRIG}, 16'h4422);
    wr(4'h5, 8'h80);
    wr(4'h3, 8'h55);
    chk(TX_TRIG, 8'h44);
    lf = lfsr(lf);
    n_rx = lf[3:0] + 2;
    repeat (n_rx) pulse(8'h10);
    pulse(8'h40);
    pulse(8'h40);
    pulse(8'h30);
    rd(4'h4, 8'h00);
    wr(4'h5, 8'h40);
    rd(4'h7, n_rx[7:0]);
    wr(4'h5, 8'hC0);
    rd(4'h7, 8'h02);
    pulse(8'h20);
    wr(4'h5, 8'h00);
    wr(4'h8, `LINE_ENH_KEY);
    rd(4'h4, n_rx[7:0] - 8'h01);
    wr(4'h8, 8'h00);
    lf = lfsr(lf);
    wr(4'h7, lf);
    rd(4'h7, lf);
    repeat (3) pulse(8'h80);
    wr(4'h5, 8'hC0);
    rd(4'h7, 8'h00);
    pulse(8'h01);
    chk(XOFF_INT, 1'h1);
    pulse(8'h02);
    chk({XOFF_INT, RESUME_INT}, 2'h1);
    pulse(8'h0C);
    pulse(8'h08);
    chk(SPECIAL_INT, 1'h0);
    rd(4'h9, 8'h04);
    wr(4'h7, 8'h80);
    pulse(8'h01);
    pulse(8'h0C);
    pulse(8'h02);
    pulse(8'h08);
    chk({XOFF_INT, SPECIAL_INT, RESUME_INT}, 3'h7);
    rd(4'h9, 8'h07);
    chk({XOFF_INT, SPECIAL_INT, RESUME_INT}, 3'h0);
    wr(4'h5, 8'h00);
    TX_BUSY <= 1'h1;
    SLEEP_PIN_IN <= 1'h1;
    cyc(6);
    chk(ASLEEP, 1'h0);
    TX_BUSY <= 1'h0;
    cyc(6);
    chk(ASLEEP, 1'h1);
    SLEEP_PIN_IN <= 1'h0;
    cyc(6);
    wr(4'h5, 8'h01);
    SW_SLEEP <= 1'h1;
    cyc(6);
    chk({ASLEEP, SLEEP_PIN_OUT, SLEEP_PIN_OE_N}, 3'h4);
    SW_SLEEP <= 1'h0;
    cyc(6);
    chk({ASLEEP, SLEEP_PIN_OUT, SLEEP_PIN_OE_N}, 3'h2);
    for (i = 0; i < 2; i = i + 1) begin
      wr(4'h5, {5'h00, i[0], 2'h0});
      ir_inv <= i[0];
      cyc(4);
      chk(RX_DATA, 1'h0);
      ir_send <= 1'h1;
      cyc(4);
      chk(RX_DATA, 1'h1);
      ir_send <= 1'h0;
    end
    wr(4'h5, 8'h08);
    THR_EMPTY <= 1'h0;
    TSR_EMPTY <= 1'h0;
    pulse(8'h40);
    cyc(1);
    chk(RTS_N, 1'h0);
    THR_EMPTY <= 1'h1;
    cyc(2);
    chk(TX_INT, 1'h0);
    pulse(8'h80);
    TSR_EMPTY <= 1'h1;
    cyc(2);
    chk({TX_INT, RTS_N}, 2'h2);
    cyc(12);
    chk(RTS_N, 1'h1);
    wr(4'h5, 8'h48);
    wr(4'h7, 8'h08);
    cyc(1);
    chk(RTS_N, 1'h0);
    wr(4'h5, 8'h00);
    TSR_EMPTY <= 1'h0;
    cyc(2);
    chk(TX_INT, 1'h1);
    stop_test;
  end
endmodule // uart_enhanced_baud_flow_config_test
